/* common/lmtc_consts.vh */
// constants for the loss-of-signal mute and threshold control block
`ifndef LMTC_CONSTS_VH
`define LMTC_CONSTS_VH
`define LMTC_NUM_CHAN        3
`define LMTC_RATE_W          2
`define LMTC_RATE_E3         2'h0
`define LMTC_RATE_DS3        2'h1
`define LMTC_RATE_STS1       2'h2
`define LMTC_THR_SEL_RESET   1'b0
`define LMTC_MUTE_EN_RESET   1'b0
`define LMTC_SYNC_RESET      3'h0
`endif

/* core/lmtc_chan_gate.v */
// per-channel mute gate in the recovered clock domain
`timescale 1ns/1ps
`include "lmtc_consts.vh"
module lmtc_chan_gate (
  // clock and reset
  input  wire rx_clk,
  input  wire rstn,
  // controls
  input  wire mute_en,
  input  wire los_declared,
  input  wire edge_sel,
  // data
  input  wire pos_in,
  input  wire neg_in,
  output reg  rx_positive_data_out,
  output reg  rx_negative_data_out
);
  // ==========================================================
  // launch registers
  reg  pos_r_reg;
  reg  neg_r_reg;
  reg  pos_f_reg;
  reg  neg_f_reg;
  wire mute_now;
  assign mute_now = mute_en & los_declared;

  always @(posedge rx_clk or negedge rstn) begin
    if (!rstn) begin
      pos_r_reg <= 1'b0;
      neg_r_reg <= 1'b0;
    end else begin
      // release on first edge after clearing
      pos_r_reg <= pos_in & ~mute_now;
      neg_r_reg <= neg_in & ~mute_now;
    end
  end

  always @(negedge rx_clk or negedge rstn) begin
    if (!rstn) begin
      pos_f_reg <= 1'b0;
      neg_f_reg <= 1'b0;
    end else begin
      pos_f_reg <= pos_in & ~mute_now;
      neg_f_reg <= neg_in & ~mute_now;
    end
  end

  // edge select is static configuration; mux is glitch-free when held
  always @* begin
    rx_positive_data_out = edge_sel ? pos_f_reg : pos_r_reg;
    rx_negative_data_out = edge_sel ? neg_f_reg : neg_r_reg;
  end
endmodule // lmtc_chan_gate

/* core/lmtc_top.v */
// loss-of-signal mute and threshold select control, three channels
`timescale 1ns/1ps
`include "lmtc_consts.vh"
module lmtc_top #(
  parameter NCH = `LMTC_NUM_CHAN
) (
  // system clock and reset
  input  wire                        clk,
  input  wire                        rstn,
  // configuration pins
  input  wire                        host_mode,
  input  wire                        mute_pin_in,
  output reg                         mute_pin_out,
  output reg                         mute_pin_oe,
  input  wire                        host_irq_n,
  input  wire                        signal_loss_threshold_select,
  input  wire [NCH*`LMTC_RATE_W-1:0] chan_rate,
  // to analog detectors
  output reg                         thr_pair_sel,
  output reg                         mute_en_status,
  // recovered clock domains
  input  wire [NCH-1:0]              rx_recovered_clock_out,
  input  wire [NCH-1:0]              rx_edge_sel,
  input  wire [NCH-1:0]              los_declared,
  input  wire [NCH-1:0]              rx_pos_in,
  input  wire [NCH-1:0]              rx_neg_in,
  output wire [NCH-1:0]              rx_positive_data_out,
  output wire [NCH-1:0]              rx_negative_data_out
);
  // ==========================================================
  // pin synchronisers, three stages, change on stages 2/3 agree
  reg  [2:0] mute_sync_reg;
  reg  [2:0] thr_sync_reg;
  reg        mute_en_reg;
  reg        thr_sel_reg;
  reg        any_ds3;
  integer    i;

  function is_ds3_sts1;
    input [`LMTC_RATE_W-1:0] r;
    begin
      is_ds3_sts1 = (r == `LMTC_RATE_DS3) || (r == `LMTC_RATE_STS1);
    end
  endfunction

  always @* begin
    any_ds3 = 1'b0;
    for (i = 0; i < NCH; i = i + 1)
      any_ds3 = any_ds3 |
        is_ds3_sts1(chan_rate[i*`LMTC_RATE_W +: `LMTC_RATE_W]);
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mute_sync_reg <= `LMTC_SYNC_RESET;
      thr_sync_reg  <= `LMTC_SYNC_RESET;
      mute_en_reg   <= `LMTC_MUTE_EN_RESET;
      thr_sel_reg   <= `LMTC_THR_SEL_RESET;
      thr_pair_sel  <= `LMTC_THR_SEL_RESET;
      mute_pin_out  <= 1'b0;
      mute_pin_oe   <= 1'b0;
      mute_en_status <= `LMTC_MUTE_EN_RESET;
    end else begin
      mute_sync_reg <= {mute_sync_reg[1:0], mute_pin_in};
      thr_sync_reg  <= {thr_sync_reg[1:0], signal_loss_threshold_select};
      // host mode clears at once, even while the stages disagree
      if (host_mode)
        mute_en_reg <= 1'b0;
      else if (mute_sync_reg[2] == mute_sync_reg[1])
        mute_en_reg <= mute_sync_reg[1];
      if (thr_sync_reg[2] == thr_sync_reg[1])
        thr_sel_reg <= thr_sync_reg[1];
      // hold last pair when no DS3/STS-1 channel
      if (any_ds3)
        thr_pair_sel <= thr_sel_reg;
      // open-drain style irq, driven only in host mode
      mute_pin_out  <= 1'b0;
      mute_pin_oe   <= host_mode & ~host_irq_n;
      mute_en_status <= mute_en_reg;
    end
  end

  // ==========================================================
  // per-channel gates share one enable
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_ch
      lmtc_chan_gate u_gate (
        .rx_clk               (rx_recovered_clock_out[g]),
        .rstn                 (rstn),
        .mute_en              (mute_en_reg),
        .los_declared         (los_declared[g]),
        .edge_sel             (rx_edge_sel[g]),
        .pos_in               (rx_pos_in[g]),
        .neg_in               (rx_neg_in[g]),
        .rx_positive_data_out (rx_positive_data_out[g]),
        .rx_negative_data_out (rx_negative_data_out[g])
      );
    end
  endgenerate
endmodule // lmtc_top

/* tb/lmtc_checker.sv */
// checker for the mute and threshold control ports
`timescale 1ns/1ps
module lmtc_checker #(
  parameter NCH = 3
) (
  // system side
  input wire             clk,
  input wire             rstn,
  input wire             host_mode,
  input wire             mute_pin_in,
  input wire             host_irq_n,
  input wire             mute_pin_out,
  input wire             mute_pin_oe,
  input wire             thr_pair_sel,
  input wire             mute_en_status,
  input wire             signal_loss_threshold_select,
  input wire [2*NCH-1:0] chan_rate,
  // recovered clock side
  input wire [NCH-1:0]   rx_recovered_clock_out,
  input wire [NCH-1:0]   los_declared,
  input wire [NCH-1:0]   rx_pos_in,
  input wire [NCH-1:0]   rx_neg_in,
  input wire [NCH-1:0]   rx_positive_data_out,
  input wire [NCH-1:0]   rx_negative_data_out
);
  wire rxc = rx_recovered_clock_out[0];
  wire fast = ^chan_rate[1:0] | ^chan_rate[3:2] | ^chan_rate[5:4];
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  a_irq_low: assert property (!mute_pin_out) else $error("irq");
  a_irq_oe: assert property (
    host_mode && !host_irq_n |-> ##[0:4] mute_pin_oe) else $error("oe");
  a_host_off: assert property (
    host_mode [*6] |-> !mute_en_status) else $error("host");
  a_mute_on: assert property (
    (mute_pin_in && !host_mode) [*6] |-> mute_en_status) else $error("en");
  a_thr_hold: assert property (
    !fast [*2] |-> $stable(thr_pair_sel)) else $error("hold");
  a_thr_pick: assert property (
    (fast && $stable(signal_loss_threshold_select)) [*6] |->
    thr_pair_sel == signal_loss_threshold_select) else $error("pick");
  // only channel 0 clock is watched: the bench ties all channels together
  a_mute_all: assert property (@(posedge rxc) mute_en_status |=>
    !mute_en_status || ((rx_positive_data_out | rx_negative_data_out) &
    $past(los_declared)) == 0) else $error("mute");
  a_pass_data: assert property (@(posedge rxc) $past(rstn) |->
    ((rx_positive_data_out ^ $past(rx_pos_in)) & ~$past(los_declared)) == 0)
    else $error("pass");
  a_pass_neg: assert property (@(posedge rxc) $past(rstn) |->
    ((rx_negative_data_out ^ $past(rx_neg_in)) & ~$past(los_declared)) == 0)
    else $error("pass neg");
endmodule // lmtc_checker
bind lmtc_top lmtc_checker #(.NCH(NCH)) u_chk (.*);

/* tb/lmtc_framer_model.sv */
// framer model sampling the recovered data
`timescale 1ns/1ps
module lmtc_framer_model (
  input wire       rx_clk,
  input wire [2:0] pos, neg,
  output reg [5:0] seen_reg);
  // launch is on the rising edge, so the falling edge sees settled data
  always @(negedge rx_clk) seen_reg <= {pos, neg};
endmodule // lmtc_framer_model

/* tb/tb_lmtc_top.sv */
// bench for the mute and threshold control block
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin bad_count++; \
  $display("[FAIL] %0t mismatch", $time); end end
module tb_lmtc_top;
  reg clk = 0, rxc = 0, rstn = 0, host_mode = 0, mute_pin_in = 0, sel = 0;
  reg host_irq_n = 1;
  reg [5:0] chan_rate = 6'h00;
  reg [2:0] los_declared = 3'h0, rx_pos_in = 3'h7, rx_neg_in = 3'h5;
  wire mute_pin_out, mute_pin_oe, thr_pair_sel, mute_en_status;
  wire [2:0] rx_positive_data_out, rx_negative_data_out;
  wire [2:0] rx_recovered_clock_out = {3{rxc}};
  wire [5:0] seen;
  integer bad_count = 0, check_count = 0;
  initial forever #12.5 clk = ~clk;
  initial begin #7; forever #30 rxc = ~rxc; end
  lmtc_top DUT (.*, .signal_loss_threshold_select(sel), .rx_edge_sel(3'h0));
  lmtc_framer_model FRM (.rx_clk(rxc), .pos(rx_positive_data_out),
    .neg(rx_negative_data_out), .seen_reg(seen));
  task step(input integer n); repeat (n) @(posedge clk); endtask
  task summarize; begin
    if (bad_count == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish; end endtask
  initial begin
    step(8); rstn <= 1; sel <= 1; step(9);
    `CHK(thr_pair_sel, 1'h0)
    chan_rate <= 6'h04; step(9);
    `CHK(thr_pair_sel, 1'h1)
    chan_rate <= 6'h20; sel <= 0; step(9);
    `CHK(thr_pair_sel, 1'h0)
    chan_rate <= 6'h00; sel <= 1; step(9);
    `CHK(thr_pair_sel, 1'h0)
    mute_pin_in <= 1; los_declared <= 3'h5; step(9);
    `CHK(seen, 6'h10)
    los_declared <= 3'h4; step(9);
    `CHK(seen, 6'h19)
    mute_pin_in <= 0; step(9);
    `CHK(seen, 6'h3d)
    host_irq_n <= 0; host_mode <= 1; mute_pin_in <= 1; step(9);
    `CHK({mute_pin_oe, mute_pin_out, mute_en_status, seen}, 9'h13d)
    summarize;
  end
  initial begin #20000; bad_count++; summarize; end
endmodule // tb_lmtc_top
